/* design/pgd_pkg.sv */
package pgd_pkg;

  // Register byte offsets
  localparam logic [6:0] OFS_G5_DATA      = 7'h00;
  localparam logic [6:0] OFS_G5_IO_EN     = 7'h04;
  localparam logic [6:0] OFS_G5_PULL      = 7'h08;
  localparam logic [6:0] OFS_G5_IRQ_FLAGS = 7'h0C;
  localparam logic [6:0] OFS_G5_IRQ_CTRL  = 7'h10;
  localparam logic [6:0] OFS_G5_DEBOUNCE  = 7'h14;
  localparam logic [6:0] OFS_G5_MODE      = 7'h18;
  localparam logic [6:0] OFS_G5_FUNC      = 7'h1C;
  localparam logic [6:0] OFS_DG_DATA      = 7'h20;
  localparam logic [6:0] OFS_DG_IO_EN     = 7'h24;
  localparam logic [6:0] OFS_DG_PULL      = 7'h28;
  localparam logic [6:0] OFS_DG_IRQ_FLAGS = 7'h2C;
  localparam logic [6:0] OFS_DG_MODE      = 7'h30;
  localparam logic [6:0] OFS_DG_FUNC      = 7'h34;
  localparam logic [6:0] OFS_PORT_CLOCK   = 7'h38;
  localparam logic [6:0] OFS_IRQ_SUMMARY  = 7'h3C;
  localparam logic [6:0] OFS_PROTECT_KEY  = 7'h40;

  // Field positions
  localparam int HI_LSB       = 14;
  localparam int LO_LSB       = 6;
  localparam int DG_HI_LSB    = 8;
  localparam int CLK_DBG_BIT  = 8;
  localparam int CLK_DIV_LSB  = 4;
  localparam int SUM_G5_BIT   = 5;
  localparam int SUM_G0_BIT   = 0;

  // Reset and fixed values
  localparam logic [15:0] G5_FUNC_FIXED  = 16'hAFFF;
  localparam logic [2:0]  DG_MODE_RESET  = 3'h7;
  localparam logic [15:0] PROTECT_UNLOCK = 16'h0096;
  localparam logic [1:0]  FUNC_DEBUG     = 2'h0;

  // Debounce settle count in divided ticks
  localparam logic [3:0]  DEBOUNCE_TICKS = 4'h4;

  typedef struct packed {
    logic [1:0] q;
  } pgd_pair_t;

  typedef struct packed {
    logic [1:0] out_level;
    logic [1:0] input_en;
    logic [1:0] output_en;
    logic [1:0] pull_direction;
    logic [1:0] pull_en;
    logic [1:0] irq_flag;
    logic [1:0] edge_select;
    logic [1:0] irq_en;
    logic [1:0] debounce_en;
    logic [7:0] mode_sel;
  } pgd_g5_t;

  typedef struct packed {
    logic [2:0] out_level;
    logic [2:0] input_en;
    logic [2:0] output_en;
    logic [2:0] pull_direction;
    logic [2:0] pull_en;
    logic [2:0] mode_sel;
    logic [5:0] function_sel;
  } pgd_dg_t;

  typedef struct packed {
    logic       run_in_debug;
    logic [3:0] port_clock_divider;
    logic [1:0] port_clock_source;
  } pgd_clk_t;

endpackage : pgd_pkg

/* design/pgd_debounce.sv */
`timescale 1ns/100ps
module pgd_debounce
  import pgd_pkg::*;
#(
  parameter logic [3:0] SETTLE = DEBOUNCE_TICKS
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  input  wire logic raw,
  output logic      filtered
);

  typedef struct packed {
    logic       level;
    logic [3:0] count;
  } pgd_deb_state_t;

  pgd_deb_state_t st;
  pgd_deb_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (raw == st.level)
      next_st.count = 4'h0;
    else if (tick)
    begin
      if (st.count == SETTLE - 4'h1)
      begin
        next_st.level = raw;
        next_st.count = 4'h0;
      end
      else
        next_st.count = st.count + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign filtered = st.level;

endmodule : pgd_debounce

/* design/pgd_port.sv */
`timescale 1ns/100ps
// Contract
// R01: Only group five pins six and seven have GPIO and pin interrupts.
// R02: Group five pins zero to five GPIO bits are reserved, read zero.
// R03: Group five outputs at bits 15-14, inputs at 7-6, same pair layout.
// R04: Group five interrupt flags clear on write one; zero leaves them.
// R05: Group five function fields fixed: 0x2 pins six/seven, 0x3 others.
// R06: Mode bit zero gives GPIO; one with function 0x3 drives display.
// R07: Debug group mode field resets to 0x7, all pins debug function.
// R08: Debug pin two GPIO output only; no input, no pull.
// R09: Debug function 0x0 routes status, serial data and clock lines.
// R10: Debug group has no interrupts; its flag register reads zero.
// R11: Clock register: debug run bit 8, divider 7-4, source 1-0, protected.
// R12: Summary register shows group five pending at bit 5, group zero bit 0.
// R13: Software unlocks with 0x0096 to key register, relocks otherwise.
// R14: Enabled edge on raw or filtered input sets the pin flag.
module pgd_port
  import pgd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [6:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  g5_pin_in,
  output logic      [1:0]  g5_pin_out,
  output logic      [1:0]  g5_pin_oe,
  output logic      [1:0]  g5_pull_up,
  output logic      [1:0]  g5_pull_down,
  output logic      [5:0]  g5_display_en,
  input  wire logic [1:0]  dg_pin_in,
  output logic      [2:0]  dg_pin_out,
  output logic      [2:0]  dg_pin_oe,
  output logic      [1:0]  dg_pull_up,
  output logic      [1:0]  dg_pull_down,
  input  wire logic        debug_status_pin,
  input  wire logic        debug_serial_out,
  input  wire logic        debug_serial_oe,
  output logic             debug_serial_pin,
  input  wire logic        debug_clock_pin,
  input  wire logic        g0_irq_pending,
  input  wire logic        debug_mode,
  output logic      [6:0]  port_clock_cfg,
  output logic             irq
);

  typedef struct packed {
    pgd_g5_t     g5;
    pgd_dg_t     dg;
    pgd_clk_t    clk;
    logic        unlocked;
    logic [1:0]  in_prev;
    logic [1:0]  g5_in_level;
    logic [1:0]  dg_in_level;
    logic [15:0] div_count;
    logic        tick;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic [1:0]  pull_up;
    logic [1:0]  pull_down;
    logic [5:0]  display_en;
    logic [2:0]  dg_out;
    logic [2:0]  dg_oe;
    logic [1:0]  dg_pu;
    logic [1:0]  dg_pd;
    logic        dbg_serial;
    logic        irq;
  } pgd_state_t;

  pgd_state_t st;
  pgd_state_t next_st;
  logic [1:0] filt;
  logic [1:0] sense;
  logic       setup;
  logic       wr;
  logic [6:0] addr;
  logic [15:0] wd;
  logic [15:0] rd;
  logic       hit;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] evt;
  logic [2:0] dg_gpio;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_deb
      pgd_debounce u_deb (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (st.tick),
        .raw      (st.g5_in_level[gi]),
        .filtered (filt[gi])
      );
    end
  endgenerate

  assign setup = psel && !penable;
  assign addr  = {paddr[6:2], 2'b00};
  assign wd    = pwdata[15:0];
  // Writes land at the access edge
  assign wr    = psel && penable && st.pready && pwrite;

  always_comb
  begin
    hit = 1'b1;
    rd  = 16'h0000;
    case (addr)
      // R03: pair layout for group five
      // R02: unused pins read zero
      OFS_G5_DATA:
        rd = {st.g5.out_level, 6'h00, st.g5_in_level, 6'h00};
      OFS_G5_IO_EN:
        rd = {st.g5.input_en, 6'h00, st.g5.output_en, 6'h00};
      OFS_G5_PULL:
        rd = {st.g5.pull_direction, 6'h00, st.g5.pull_en, 6'h00};
      OFS_G5_IRQ_FLAGS:
        rd = {8'h00, st.g5.irq_flag, 6'h00};
      OFS_G5_IRQ_CTRL:
        rd = {st.g5.edge_select, 6'h00, st.g5.irq_en, 6'h00};
      OFS_G5_DEBOUNCE:
        rd = {8'h00, st.g5.debounce_en, 6'h00};
      OFS_G5_MODE:
        rd = {8'h00, st.g5.mode_sel};
      // R05: fixed function fields
      OFS_G5_FUNC:
        rd = G5_FUNC_FIXED;
      OFS_DG_DATA:
        rd = {5'h00, st.dg.out_level, 6'h00, st.dg_in_level};
      OFS_DG_IO_EN:
        rd = {5'h00, st.dg.input_en, 5'h00, st.dg.output_en};
      OFS_DG_PULL:
        rd = {5'h00, st.dg.pull_direction, 5'h00, st.dg.pull_en};
      // R10: debug flag register reads zero
      OFS_DG_IRQ_FLAGS:
        rd = 16'h0000;
      OFS_DG_MODE:
        rd = {13'h0000, st.dg.mode_sel};
      OFS_DG_FUNC:
        rd = {10'h000, st.dg.function_sel};
      OFS_PORT_CLOCK:
        rd = {7'h00, st.clk.run_in_debug, st.clk.port_clock_divider,
              2'b00, st.clk.port_clock_source};
      // R12: group summary
      OFS_IRQ_SUMMARY:
        rd = {10'h000, |st.g5.irq_flag, 4'h0, g0_irq_pending};
      OFS_PROTECT_KEY:
        rd = {15'h0000, st.unlocked};
      default:
        hit = 1'b0;
    endcase
  end

  // R14: edge detect on raw or filtered input
  always_comb
  begin
    sense = (st.g5.debounce_en & filt) | (~st.g5.debounce_en & st.g5_in_level);
    rise  = sense & ~st.in_prev;
    fall  = ~sense & st.in_prev;
    evt   = st.g5.irq_en & ((st.g5.edge_select & fall)
                          | (~st.g5.edge_select & rise));
  end

  always_comb
  begin
    next_st = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.g5_in_level = g5_pin_in & st.g5.input_en;
    next_st.dg_in_level = dg_pin_in & st.dg.input_en[1:0];
    next_st.in_prev = sense;
    next_st.tick = (st.div_count == 16'h0000);
    next_st.div_count = next_st.tick
      ? (16'h0001 << st.clk.port_clock_divider) - 16'h0001
      : st.div_count - 16'h0001;
    if (debug_mode && !st.clk.run_in_debug)
    begin
      next_st.tick = 1'b0;
      next_st.div_count = st.div_count;
    end
    if (setup)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = {16'h0000, rd};
    end
    if (wr && hit)
    begin
      case (addr)
        OFS_G5_DATA:
          next_st.g5.out_level = wd[HI_LSB +: 2];
        OFS_G5_IO_EN:
        begin
          next_st.g5.input_en  = wd[HI_LSB +: 2];
          next_st.g5.output_en = wd[LO_LSB +: 2];
        end
        OFS_G5_PULL:
        begin
          next_st.g5.pull_direction = wd[HI_LSB +: 2];
          next_st.g5.pull_en        = wd[LO_LSB +: 2];
        end
        OFS_G5_IRQ_CTRL:
        begin
          next_st.g5.edge_select = wd[HI_LSB +: 2];
          next_st.g5.irq_en      = wd[LO_LSB +: 2];
        end
        OFS_G5_DEBOUNCE:
          next_st.g5.debounce_en = wd[LO_LSB +: 2];
        OFS_G5_MODE:
          next_st.g5.mode_sel = wd[7:0];
        OFS_DG_DATA:
          next_st.dg.out_level = wd[DG_HI_LSB +: 3];
        // R08: pin two enable and pull bits kept as plain storage
        OFS_DG_IO_EN:
        begin
          next_st.dg.input_en  = wd[DG_HI_LSB +: 3];
          next_st.dg.output_en = wd[2:0];
        end
        OFS_DG_PULL:
        begin
          next_st.dg.pull_direction = wd[DG_HI_LSB +: 3];
          next_st.dg.pull_en        = wd[2:0];
        end
        OFS_DG_MODE:
          next_st.dg.mode_sel = wd[2:0];
        OFS_DG_FUNC:
          next_st.dg.function_sel = wd[5:0];
        // R11: protected clock fields
        OFS_PORT_CLOCK:
          if (st.unlocked)
          begin
            next_st.clk.run_in_debug       = wd[CLK_DBG_BIT];
            next_st.clk.port_clock_divider = wd[CLK_DIV_LSB +: 4];
            next_st.clk.port_clock_source  = wd[1:0];
          end
        OFS_PROTECT_KEY:
          // R13: key unlocks protection
          next_st.unlocked = (wd == PROTECT_UNLOCK);
        default:
          next_st.unlocked = st.unlocked;
      endcase
    end
    // R04: write one clears, event wins
    if (wr && hit && addr == OFS_G5_IRQ_FLAGS)
      next_st.g5.irq_flag = st.g5.irq_flag & ~wd[LO_LSB +: 2];
    next_st.g5.irq_flag = next_st.g5.irq_flag | evt;
    next_st.irq = |next_st.g5.irq_flag;
    // R01: GPIO drive only on pins six and seven
    // R06: mode bit selects GPIO or display
    next_st.pin_oe    = st.g5.output_en & ~st.g5.mode_sel[7:6];
    next_st.pin_out   = st.g5.out_level;
    next_st.pull_up   = st.g5.pull_en & ~st.g5.output_en
                      & st.g5.pull_direction & ~st.g5.mode_sel[7:6];
    next_st.pull_down = st.g5.pull_en & ~st.g5.output_en
                      & ~st.g5.pull_direction & ~st.g5.mode_sel[7:6];
    next_st.display_en = st.g5.mode_sel[5:0];
    // R09: debug function routing
    dg_gpio = ~st.dg.mode_sel;
    next_st.dg_out = st.dg.out_level;
    next_st.dg_oe  = st.dg.output_en & dg_gpio;
    // R08: pin two output only
    next_st.dg_oe[2] = dg_gpio[2] ? 1'b1 : 1'b0;
    if (st.dg.mode_sel[0] && st.dg.function_sel[1:0] == FUNC_DEBUG)
    begin
      next_st.dg_out[0] = debug_status_pin;
      next_st.dg_oe[0]  = 1'b1;
    end
    if (st.dg.mode_sel[1] && st.dg.function_sel[3:2] == FUNC_DEBUG)
    begin
      next_st.dg_out[1] = debug_serial_out;
      next_st.dg_oe[1]  = debug_serial_oe;
    end
    if (st.dg.mode_sel[2] && st.dg.function_sel[5:4] == FUNC_DEBUG)
    begin
      next_st.dg_out[2] = debug_clock_pin;
      next_st.dg_oe[2]  = 1'b1;
    end
    next_st.dbg_serial = dg_pin_in[1];
    next_st.dg_pu = st.dg.pull_en[1:0] & ~st.dg.output_en[1:0]
                  & st.dg.pull_direction[1:0] & dg_gpio[1:0];
    next_st.dg_pd = st.dg.pull_en[1:0] & ~st.dg.output_en[1:0]
                  & ~st.dg.pull_direction[1:0] & dg_gpio[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      // R07: debug function after reset
      st.dg.mode_sel <= DG_MODE_RESET;
      st.dg_oe <= 3'h5;
    end
    else
      st <= next_st;
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign g5_pin_out       = st.pin_out;
  assign g5_pin_oe        = st.pin_oe;
  assign g5_pull_up       = st.pull_up;
  assign g5_pull_down     = st.pull_down;
  assign g5_display_en    = st.display_en;
  assign dg_pin_out       = st.dg_out;
  assign dg_pin_oe        = st.dg_oe;
  assign dg_pull_up       = st.dg_pu;
  assign dg_pull_down     = st.dg_pd;
  assign debug_serial_pin = st.dbg_serial;
  assign port_clock_cfg   = st.clk;
  assign irq              = st.irq;

endmodule : pgd_port

/* verif/pgd_port_checker.sv */
`timescale 1ns/100ps
module pgd_port_checker
  import pgd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [6:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        g0_irq_pending,
  input wire logic [6:0]  port_clock_cfg,
  input wire logic [5:0]  g5_display_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire setup = psel & ~penable;
  wire rd    = pready & ~pwrite;
  wire acc_wr = psel & penable & pready & pwrite;

  a_ready_setup: assert property (setup |=> pready && penable)
    else $error("ready missing after setup");
  a_ready_cause: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  a_ok_mapped: assert property (pready && paddr[1:0] == 2'h0
    && paddr <= 7'h40 |-> !pslverr) else $error("mapped access refused");
  a_rd_upper: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_func_fixed: assert property (
    rd && paddr == 7'(OFS_G5_FUNC) |-> prdata[15:0] == G5_FUNC_FIXED)
    else $error("function field not fixed");
  a_g5_rsvd: assert property (rd && paddr == 7'(OFS_G5_DATA)
    |-> prdata[13:8] == 6'h00 && prdata[5:0] == 6'h00)
    else $error("reserved data bits set");
  a_dg_noirq: assert property (
    rd && paddr == 7'(OFS_DG_IRQ_FLAGS) |-> prdata[15:0] == 16'h0000)
    else $error("debug flags not zero");
  a_sum_g0: assert property (rd && paddr == 7'(OFS_IRQ_SUMMARY)
    && $stable(g0_irq_pending) |-> prdata[0] == g0_irq_pending)
    else $error("summary bit 0 wrong");
  a_clk_write: assert property ($changed(port_clock_cfg) |->
    $past(acc_wr && paddr == 7'(OFS_PORT_CLOCK)))
    else $error("clock config changed without write");
  a_disp_write: assert property ($changed(g5_display_en) |->
    $past(acc_wr && paddr == 7'(OFS_G5_MODE), 2))
    else $error("display enable changed without write");
endmodule : pgd_port_checker

bind pgd_port pgd_port_checker chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .g0_irq_pending,
  .port_clock_cfg, .g5_display_en);

/* verif/pgd_pin_model.sv */
`timescale 1ns/100ps
module pgd_pin_model (
  input  wire logic [1:0] g5_ext,
  input  wire logic [1:0] dg_ext,
  input  wire logic [1:0] g5_pin_out,
  input  wire logic [1:0] g5_pin_oe,
  input  wire logic [1:0] g5_pull_up,
  input  wire logic [1:0] g5_pull_down,
  input  wire logic [2:0] dg_pin_out,
  input  wire logic [2:0] dg_pin_oe,
  input  wire logic [1:0] dg_pull_up,
  input  wire logic [1:0] dg_pull_down,
  output logic      [1:0] g5_pin_in,
  output logic      [1:0] dg_pin_in
);
  // Pin level: driver first, then pull, then outside source
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      g5_pin_in[i] = g5_pin_oe[i] ? g5_pin_out[i] : g5_pull_up[i] ? 1'b1 :
                     g5_pull_down[i] ? 1'b0 : g5_ext[i];
      dg_pin_in[i] = dg_pin_oe[i] ? dg_pin_out[i] : dg_pull_up[i] ? 1'b1 :
                     dg_pull_down[i] ? 1'b0 : dg_ext[i];
    end
  end
endmodule : pgd_pin_model

/* verif/tb.sv */
`timescale 1ns/100ps
module tb
  import pgd_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [6:0]  paddr, port_clock_cfg;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0]  g5_pin_in, g5_pin_out, g5_pin_oe, g5_pull_up, g5_pull_down;
  logic [1:0]  dg_pin_in, dg_pull_up, dg_pull_down, g5_ext, dg_ext;
  logic [2:0]  dg_pin_out, dg_pin_oe;
  logic [5:0]  g5_display_en;
  logic        debug_status_pin, debug_serial_out, debug_serial_oe;
  logic        debug_serial_pin, debug_clock_pin, g0_irq_pending, debug_mode;
  logic        e;
  int          errors, cmp_count, cyc;

  pgd_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .g5_pin_in, .g5_pin_out, .g5_pin_oe,
    .g5_pull_up, .g5_pull_down, .g5_display_en, .dg_pin_in, .dg_pin_out,
    .dg_pin_oe, .dg_pull_up, .dg_pull_down, .debug_status_pin,
    .debug_serial_out, .debug_serial_oe, .debug_serial_pin,
    .debug_clock_pin, .g0_irq_pending, .debug_mode, .port_clock_cfg, .irq);

  pgd_pin_model pins (.g5_ext, .dg_ext, .g5_pin_out, .g5_pin_oe, .g5_pull_up,
    .g5_pull_down, .dg_pin_out, .dg_pin_oe, .dg_pull_up, .dg_pull_down,
    .g5_pin_in, .dg_pin_in);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errors++;
      end_sim();
    end
  end

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task apb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [6:0] a, input logic [31:0] d);
    apb(1'b1, 7'(a), d);
  endtask : wr

  task rd(input string n, input logic [6:0] a, input logic [31:0] x);
    apb(1'b0, 7'(a), 32'h0);
    chk(n, x, rv);
  endtask : rd

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {g5_ext, debug_serial_out, debug_serial_oe, debug_clock_pin} <= '0;
    {debug_status_pin, g0_irq_pending, debug_mode, dg_ext} <= 5'h1A;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd("io_en reset", OFS_G5_IO_EN, 32'h0);
    rd("dg mode reset", OFS_DG_MODE, 32'h7);
    rd("g5 function", OFS_G5_FUNC, 32'hAFFF);
    rd("dg flags", OFS_DG_IRQ_FLAGS, 32'h0);
    rd("clock reset", OFS_PORT_CLOCK, 32'h0);
    rd("summary g0", OFS_IRQ_SUMMARY, 32'h1);
    chk("dg oe", 32'(dg_pin_oe), 32'h5);
    chk("status out", 32'(dg_pin_out[0]), 32'h1);
    chk("clock out", 32'(dg_pin_out[2]), 32'h0);
    chk("serial in", 32'(debug_serial_pin), 32'h1);
    apb(1'b0, 7'h44, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    $display("test reset done");
    wr(OFS_G5_IO_EN, 32'hFFFF);
    rd("io_en mask", OFS_G5_IO_EN, 32'hC0C0);
    wr(OFS_G5_PULL, 32'hFFFF);
    rd("pull mask", OFS_G5_PULL, 32'hC0C0);
    wr(OFS_G5_PULL, 32'h0);
    wr(OFS_G5_DATA, 32'h8000);
    repeat (2) @(posedge pclk);
    rd("loopback", OFS_G5_DATA, 32'h8080);
    chk("pin out", 32'(g5_pin_out), 32'h2);
    chk("pin oe", 32'(g5_pin_oe), 32'h3);
    wr(OFS_G5_MODE, 32'hFFFF);
    rd("mode", OFS_G5_MODE, 32'hFF);
    chk("display", 32'(g5_display_en), 32'h3F);
    wr(OFS_G5_MODE, 32'h0);
    $display("test gpio done");
    wr(OFS_G5_IO_EN, 32'hC000);
    wr(OFS_G5_IRQ_CTRL, 32'h00C0);
    g5_ext <= 2'b11;
    repeat (4) @(posedge pclk);
    rd("rise flags", OFS_G5_IRQ_FLAGS, 32'hC0);
    chk("irq", 32'(irq), 32'h1);
    rd("summary g5", OFS_IRQ_SUMMARY, 32'h21);
    wr(OFS_G5_IRQ_FLAGS, 32'h0);
    rd("zero write", OFS_G5_IRQ_FLAGS, 32'hC0);
    wr(OFS_G5_IRQ_FLAGS, 32'h40);
    rd("one clear", OFS_G5_IRQ_FLAGS, 32'h80);
    wr(OFS_G5_IRQ_FLAGS, 32'h80);
    rd("all clear", OFS_G5_IRQ_FLAGS, 32'h0);
    chk("irq low", 32'(irq), 32'h0);
    wr(OFS_G5_IRQ_CTRL, 32'h80C0);
    g5_ext <= 2'b00;
    repeat (4) @(posedge pclk);
    rd("fall flags", OFS_G5_IRQ_FLAGS, 32'h80);
    wr(OFS_G5_IRQ_FLAGS, 32'h80);
    $display("test irq done");
    wr(OFS_G5_DEBOUNCE, 32'h00C0);
    rd("debounce en", OFS_G5_DEBOUNCE, 32'hC0);
    wr(OFS_G5_IRQ_CTRL, 32'h00C0);
    g5_ext <= 2'b11;
    repeat (3) @(posedge pclk);
    rd("filter hold", OFS_G5_IRQ_FLAGS, 32'h0);
    repeat (8) @(posedge pclk);
    rd("filter flags", OFS_G5_IRQ_FLAGS, 32'hC0);
    wr(OFS_G5_IRQ_FLAGS, 32'hC0);
    g0_irq_pending <= 1'b0;
    rd("summary idle", OFS_IRQ_SUMMARY, 32'h0);
    $display("test debounce done");
    wr(OFS_PORT_CLOCK, 32'h01F3);
    rd("locked", OFS_PORT_CLOCK, 32'h0);
    apb(1'b1, 7'h40, 32'h0096);
    wr(OFS_PORT_CLOCK, 32'h01F3);
    rd("unlocked", OFS_PORT_CLOCK, 32'h01F3);
    chk("clock cfg", 32'(port_clock_cfg), 32'h7F);
    apb(1'b1, 7'h40, 32'h0);
    wr(OFS_PORT_CLOCK, 32'h0);
    rd("relocked", OFS_PORT_CLOCK, 32'h01F3);
    $display("test protect done");
    wr(OFS_DG_MODE, 32'h0);
    wr(OFS_DG_DATA, 32'h0400);
    repeat (2) @(posedge pclk);
    chk("dg2 out", 32'(dg_pin_out[2]), 32'h1);
    chk("dg2 oe", 32'(dg_pin_oe[2]), 32'h1);
    $display("test debug group done");
    end_sim();
  end
endmodule : tb
